/* File: mbl_axil.sv */
// AXI4-Lite slave front end producing register strobes
`include "mbl_consts.svh"

module mbl_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`MBL_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`MBL_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [`MBL_ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [`MBL_ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    logic aw_got;
    logic w_got;
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire issue = aw_got && w_got && !bvalid;
    wire ar_take = arvalid && arready;

    assign rd_addr = araddr;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            aw_got <= 1'b0;
            wr_addr <= '0;
        end
        else if (aw_take)
        begin
            awready <= 1'b0;
            aw_got <= 1'b1;
            wr_addr <= awaddr;
        end
        else if (issue)
            aw_got <= 1'b0;
        else if (bvalid && bready)
            awready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready <= 1'b1;
            w_got <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end
        else if (w_take)
        begin
            wready <= 1'b0;
            w_got <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end
        else if (issue)
            w_got <= 1'b0;
        else if (bvalid && bready)
            wready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_en <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `MBL_RESP_OKAY;
        end
        else
        begin
            wr_en <= issue;
            if (issue)
            begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? `MBL_RESP_OKAY : `MBL_RESP_SLVERR;
            end
            else if (bready)
                bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `MBL_RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_ok ? `MBL_RESP_OKAY : `MBL_RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule // mbl_axil

/* File: mbl_consts.svh */
// Offsets, field positions, reset values and program counter steps of the bit-logic core
`ifndef MBL_CONSTS_SVH
`define MBL_CONSTS_SVH

`define MBL_ADDR_W 8
`define MBL_OFS_EXEC 8'h00
`define MBL_OFS_WREG 8'h04
`define MBL_OFS_PC 8'h08
`define MBL_OFS_PAGE 8'h0c
`define MBL_OFS_TABLE_HIGH_POINTER 8'h10
`define MBL_OFS_STATUS 8'h14
`define MBL_OFS_FADDR 8'h18
`define MBL_OFS_FDATA 8'h1c
`define MBL_OFS_SSEL 8'h20
`define MBL_OFS_SDATA 8'h24

`define MBL_EXEC_OP_LSB 0
`define MBL_EXEC_BIT_LSB 4
`define MBL_EXEC_REG_LSB 8
`define MBL_EXEC_IMM_LSB 16

`define MBL_ST_ZERO 0
`define MBL_ST_BUSY 1
`define MBL_ST_SP_LSB 4

`define MBL_PC_W 10
`define MBL_FILE_DEPTH 64
`define MBL_STACK_DEPTH 8
`define MBL_SP_W 3

`define MBL_RST_BYTE 8'h00
`define MBL_RST_PC 10'h000
`define MBL_PC_STEP 10'h001
`define MBL_PC_SKIP 10'h002

`define MBL_RESP_OKAY 2'b00
`define MBL_RESP_SLVERR 2'b10

`endif

/* File: mbl_core.sv */
// Execution core for the and-immediate, set-bit, skip and call group
// What this block does
// - And immediate into working register, zero flag
// - Set one bit of file register
// - Skip if clear: two cycles when bit zero
// - Skip if set: two cycles when bit one
// - Calls push program counter plus one
// - Direct call: page buffer and address, two cycles
// - Indirect call: pointer low bits and working register
// - Table high pointer holds target high byte
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "mbl_consts.svh"

module mbl_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`MBL_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`MBL_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    logic wr_en;
    logic [`MBL_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [`MBL_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_ok;
    logic rd_ok;

    logic [7:0] working_register;
    logic zero_flag;
    logic [`MBL_PC_W-1:0] program_counter;
    logic [1:0] program_counter_page_buffer;
    logic [7:0] table_high_pointer;
    logic [5:0] file_addr;
    logic [`MBL_SP_W-1:0] stack_sel;
    logic [31:0] last_exec;
    logic [`MBL_PC_W-1:0] pend_pc;
    logic [7:0] file_q [`MBL_FILE_DEPTH];
    mbl_pkg::mbl_state_t state;
    logic [`MBL_SP_W-1:0] sp;
    logic [`MBL_PC_W-1:0] stack_rd;

    mbl_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Write decode
    wire lane0 = wr_strb[0];
    wire sel_exec = wr_en && wr_addr == `MBL_OFS_EXEC && wr_strb == 4'hf;
    wire sel_wreg = wr_en && lane0 && wr_addr == `MBL_OFS_WREG;
    wire sel_pc = wr_en && wr_strb[1:0] == 2'h3 && wr_addr == `MBL_OFS_PC;
    wire sel_page = wr_en && lane0 && wr_addr == `MBL_OFS_PAGE;
    wire sel_table_high_pointer = wr_en && lane0 && wr_addr == `MBL_OFS_TABLE_HIGH_POINTER;
    wire sel_faddr = wr_en && lane0 && wr_addr == `MBL_OFS_FADDR;
    wire sel_fdata = wr_en && lane0 && wr_addr == `MBL_OFS_FDATA;
    wire sel_ssel = wr_en && lane0 && wr_addr == `MBL_OFS_SSEL;

    assign wr_ok = wr_addr == `MBL_OFS_EXEC || wr_addr == `MBL_OFS_WREG
        || wr_addr == `MBL_OFS_PC || wr_addr == `MBL_OFS_PAGE
        || wr_addr == `MBL_OFS_TABLE_HIGH_POINTER || wr_addr == `MBL_OFS_FADDR
        || wr_addr == `MBL_OFS_FDATA || wr_addr == `MBL_OFS_SSEL;

    // Instruction fields
    wire [3:0] op = wr_data[`MBL_EXEC_OP_LSB +: 4];
    wire [2:0] bit_sel = wr_data[`MBL_EXEC_BIT_LSB +: 3];
    wire [5:0] reg_sel = wr_data[`MBL_EXEC_REG_LSB +: 6];
    wire [7:0] imm = wr_data[`MBL_EXEC_IMM_LSB +: 8];

    // Issue only while idle; exec writes during the second cycle are dropped
    wire issue = sel_exec && state == mbl_pkg::MBL_IDLE;
    wire is_and = issue && op == mbl_pkg::MBL_OP_AND_IMM;
    wire is_set = issue && op == mbl_pkg::MBL_OP_SET_BIT;
    wire is_sclr = issue && op == mbl_pkg::MBL_OP_SKIP_CLR;
    wire is_sset = issue && op == mbl_pkg::MBL_OP_SKIP_SET;
    wire is_cdir = issue && op == mbl_pkg::MBL_OP_CALL_DIR;
    wire is_cind = issue && op == mbl_pkg::MBL_OP_CALL_IND;

    wire tested_bit = file_q[reg_sel][bit_sel];
    wire skip = (is_sclr && !tested_bit) || (is_sset && tested_bit);
    wire is_call = is_cdir || is_cind;
    wire two_cycle = skip || is_call;
    wire [`MBL_PC_W-1:0] pc_next_seq = program_counter + `MBL_PC_STEP;
    wire [7:0] and_result = working_register & imm;
    wire [`MBL_PC_W-1:0] dir_target = {program_counter_page_buffer, imm};
    wire [`MBL_PC_W-1:0] ind_target = {table_high_pointer[1:0], working_register};

    wire [`MBL_PC_W-1:0] next_pend_pc = is_cdir ? dir_target
        : is_cind ? ind_target
        : program_counter + `MBL_PC_SKIP;

    // File register write port: set-bit or a bus write to FDATA, set-bit wins
    wire file_we = is_set || sel_fdata;
    wire [5:0] file_wa = is_set ? reg_sel : file_addr;
    wire [7:0] file_wd = is_set ? (file_q[reg_sel] | (8'h01 << bit_sel))
        : wr_data[7:0];

    for (genvar i = 0; i < `MBL_FILE_DEPTH; i++)
    begin : g_file
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                file_q[i] <= `MBL_RST_BYTE;
            else if (file_we && file_wa == 6'(i))
                file_q[i] <= file_wd;
        end
    end

    mbl_stack u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(is_call),
        .push_data(pc_next_seq),
        .rd_idx(stack_sel),
        .rd_data(stack_rd),
        .sp(sp)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= mbl_pkg::MBL_IDLE;
            pend_pc <= `MBL_RST_PC;
        end
        else
        begin
            case (state)
                mbl_pkg::MBL_IDLE:
                    if (two_cycle)
                    begin
                        state <= mbl_pkg::MBL_SECOND;
                        pend_pc <= next_pend_pc;
                    end
                mbl_pkg::MBL_SECOND:
                    state <= mbl_pkg::MBL_IDLE;
                default:
                    state <= mbl_pkg::MBL_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            program_counter <= `MBL_RST_PC;
        else if (state == mbl_pkg::MBL_SECOND)
            program_counter <= pend_pc;
        else if (issue && !two_cycle)
            program_counter <= pc_next_seq;
        else if (sel_pc && state == mbl_pkg::MBL_IDLE)
            program_counter <= wr_data[`MBL_PC_W-1:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            working_register <= `MBL_RST_BYTE;
            zero_flag <= 1'b0;
        end
        else if (is_and)
        begin
            working_register <= and_result;
            zero_flag <= and_result == 8'h00;
        end
        else if (sel_wreg)
            working_register <= wr_data[7:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            program_counter_page_buffer <= 2'h0;
            table_high_pointer <= `MBL_RST_BYTE;
            file_addr <= 6'h00;
            stack_sel <= '0;
            last_exec <= 32'h0000_0000;
        end
        else
        begin
            if (sel_page)
                program_counter_page_buffer <= wr_data[1:0];
            if (sel_table_high_pointer)
                table_high_pointer <= wr_data[7:0];
            if (sel_faddr)
                file_addr <= wr_data[5:0];
            if (sel_ssel)
                stack_sel <= wr_data[`MBL_SP_W-1:0];
            if (issue)
                last_exec <= wr_data;
        end
    end

    // Read mux
    wire [31:0] status_word = 32'(zero_flag) << `MBL_ST_ZERO
        | 32'(state == mbl_pkg::MBL_SECOND) << `MBL_ST_BUSY
        | 32'(sp) << `MBL_ST_SP_LSB;

    wire wr_ok_rd = rd_addr == `MBL_OFS_EXEC || rd_addr == `MBL_OFS_WREG
        || rd_addr == `MBL_OFS_PC || rd_addr == `MBL_OFS_PAGE
        || rd_addr == `MBL_OFS_TABLE_HIGH_POINTER || rd_addr == `MBL_OFS_STATUS
        || rd_addr == `MBL_OFS_FADDR || rd_addr == `MBL_OFS_FDATA
        || rd_addr == `MBL_OFS_SSEL || rd_addr == `MBL_OFS_SDATA;
    assign rd_ok = wr_ok_rd;

    assign rd_data = rd_addr == `MBL_OFS_EXEC ? last_exec
        : rd_addr == `MBL_OFS_WREG ? 32'(working_register)
        : rd_addr == `MBL_OFS_PC ? 32'(program_counter)
        : rd_addr == `MBL_OFS_PAGE ? 32'(program_counter_page_buffer)
        : rd_addr == `MBL_OFS_TABLE_HIGH_POINTER ? 32'(table_high_pointer)
        : rd_addr == `MBL_OFS_STATUS ? status_word
        : rd_addr == `MBL_OFS_FADDR ? 32'(file_addr)
        : rd_addr == `MBL_OFS_FDATA ? 32'(file_q[file_addr])
        : rd_addr == `MBL_OFS_SSEL ? 32'(stack_sel)
        : rd_addr == `MBL_OFS_SDATA ? 32'(stack_rd)
        : 32'h0000_0000;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    and_imm_a: assert property (is_and |=> working_register == ($past(working_register)
        & $past(imm)) && zero_flag == (working_register == 8'h00)
        && state == mbl_pkg::MBL_IDLE)
        else $error("and-immediate result or zero flag wrong");

    set_bit_a: assert property (is_set |=> file_q[$past(reg_sel)][$past(bit_sel)]
        && $stable(zero_flag) && state == mbl_pkg::MBL_IDLE
        && program_counter == $past(program_counter) + `MBL_PC_STEP)
        else $error("set-bit did not set the bit in one cycle");

    skip_clear_a: assert property (is_sclr && !tested_bit |=>
        state == mbl_pkg::MBL_SECOND ##1 state == mbl_pkg::MBL_IDLE
        && program_counter == $past(program_counter, 2) + `MBL_PC_SKIP && $stable(zero_flag))
        else $error("skip-if-clear did not skip over two cycles");

    skip_set_a: assert property (is_sset && tested_bit |=>
        state == mbl_pkg::MBL_SECOND ##1 state == mbl_pkg::MBL_IDLE
        && program_counter == $past(program_counter, 2) + `MBL_PC_SKIP)
        else $error("skip-if-set did not skip over two cycles");

    no_skip_a: assert property ((is_sset && !tested_bit) || (is_sclr && tested_bit)
        |=> state == mbl_pkg::MBL_IDLE
        && program_counter == $past(program_counter) + `MBL_PC_STEP)
        else $error("untaken skip did not finish in one cycle");

    call_push_a: assert property (is_call |=>
        u_stack.entry[$past(sp)] == $past(program_counter) + `MBL_PC_STEP)
        else $error("call did not push the return address");

    direct_call_a: assert property (is_cdir |=> state == mbl_pkg::MBL_SECOND
        ##1 program_counter == {$past(program_counter_page_buffer, 2), $past(imm, 2)})
        else $error("direct call target or length wrong");

    indirect_call_a: assert property (is_cind |=> state == mbl_pkg::MBL_SECOND
        ##1 program_counter == {$past(table_high_pointer[1:0], 2),
        $past(working_register, 2)})
        else $error("indirect call target or length wrong");

    pointer_write_a: assert property (sel_table_high_pointer |=> table_high_pointer == $past(wr_data[7:0]))
        else $error("table high pointer did not take the written byte");

    call_sp_a: assert property (is_call |=> sp == $past(sp) + `MBL_SP_W'(1))
        else $error("call did not advance the stack pointer");

    cover_and_c: cover property (is_and ##1 zero_flag);
    cover_skip_c: cover property (is_sclr && !tested_bit);
    cover_cind_c: cover property (is_cind ##1 state == mbl_pkg::MBL_SECOND);

endmodule // mbl_core

/* File: mbl_pkg.sv */
// Types of the bit-logic core
package mbl_pkg;

    typedef enum logic [3:0] {
        MBL_OP_NOP = 4'h0,
        MBL_OP_AND_IMM = 4'h1,
        MBL_OP_SET_BIT = 4'h2,
        MBL_OP_SKIP_CLR = 4'h3,
        MBL_OP_SKIP_SET = 4'h4,
        MBL_OP_CALL_DIR = 4'h5,
        MBL_OP_CALL_IND = 4'h6
    } mbl_op_t;

    typedef enum logic [1:0] {
        MBL_IDLE = 2'b01,
        MBL_SECOND = 2'b10
    } mbl_state_t;

endpackage

/* File: mbl_stack.sv */
// Return stack held in flip-flops
`include "mbl_consts.svh"

module mbl_stack (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic push,
    input wire logic [`MBL_PC_W-1:0] push_data,
    input wire logic [`MBL_SP_W-1:0] rd_idx,
    output logic [`MBL_PC_W-1:0] rd_data,
    output logic [`MBL_SP_W-1:0] sp
);

    logic [`MBL_PC_W-1:0] entry [`MBL_STACK_DEPTH];

    for (genvar i = 0; i < `MBL_STACK_DEPTH; i++)
    begin : g_entry
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
                entry[i] <= `MBL_RST_PC;
            else if (push && sp == `MBL_SP_W'(i))
                entry[i] <= push_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sp <= '0;
        else if (push)
            sp <= sp + `MBL_SP_W'(1);
    end

    assign rd_data = entry[rd_idx];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    push_write_a: assert property (push |=> entry[$past(sp)] == $past(push_data)
        && sp == $past(sp) + `MBL_SP_W'(1))
        else $error("stack push did not store or advance");

    sp_hold_a: assert property (!push |=> $stable(sp))
        else $error("stack pointer moved without a push");

endmodule // mbl_stack

/* File: tb_top.sv */
// Self-checking bench for the bit-logic execution core over AXI4-Lite
`include "mbl_consts.svh"

`define CHK(got, exp) \
    begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk;
    logic aresetn;
    logic [`MBL_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [`MBL_ADDR_W-1:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    int error_cnt;
    int n_tests;

    mbl_core DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic no_answer();
        error_cnt++;
        $display("mismatch at %0t: no response", $time);
        report_and_stop();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        bit aw_done;
        bit w_done;
        bit got;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64 && !got; n++)
        begin
            @(posedge aclk);
            if (!aw_done && awready)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid)
            begin
                got = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        if (!got)
            no_answer();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_done;
        bit got;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64 && !got; n++)
        begin
            @(posedge aclk);
            if (!ar_done && arready)
            begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid)
            begin
                got = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        if (!got)
            no_answer();
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hf, r);
        `CHK(r, `MBL_RESP_OKAY)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        `CHK(r, `MBL_RESP_OKAY)
        `CHK(d, exp)
    endtask

    function automatic logic [31:0] mk(input logic [3:0] op, input logic [2:0] b,
                                       input logic [5:0] rg, input logic [7:0] imm);
        return {8'h00, imm, 2'b00, rg, 1'b0, b, op};
    endfunction

    function automatic logic [31:0] st(input logic z, input logic [2:0] sp);
        return {25'h0000000, sp, 3'b000, z};
    endfunction

    // Skip cases on file register 63 holding 8'h5e
    logic [3:0] sk_op [5] = '{4'h3, 4'h3, 4'h3, 4'h4, 4'h4};
    logic [2:0] sk_bit [5] = '{3'h0, 3'h1, 3'h7, 3'h3, 3'h0};
    logic [9:0] sk_step [5] = '{10'h002, 10'h001, 10'h002, 10'h002, 10'h001};

    initial
    begin
        logic [9:0] ctr;
        logic [9:0] ret;
        logic [31:0] d;
        logic [1:0] r;
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`MBL_OFS_STATUS, st(1'b0, 3'h0));
        rd_chk(`MBL_OFS_PC, 32'h00000000);
        axi_wr(8'h28, 32'h12345678, 4'hf, r);
        `CHK(r, `MBL_RESP_SLVERR)
        axi_rd(8'h28, d, r);
        `CHK(r, `MBL_RESP_SLVERR)
        `CHK(d, 32'h00000000)
        // And immediate, nonzero then zero result
        wr_ok(`MBL_OFS_WREG, 32'h0000005a);
        wr_ok(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_AND_IMM, 3'h0, 6'h00, 8'haf));
        rd_chk(`MBL_OFS_WREG, 32'h0000000a);
        rd_chk(`MBL_OFS_STATUS, st(1'b0, 3'h0));
        wr_ok(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_AND_IMM, 3'h0, 6'h00, 8'h00));
        rd_chk(`MBL_OFS_WREG, 32'h00000000);
        rd_chk(`MBL_OFS_PC, 32'h00000002);
        ctr = 10'h002;
        // Set every bit of one register in turn; zero flag must survive
        wr_ok(`MBL_OFS_FADDR, 32'h00000005);
        for (int b = 0; b < 8; b++)
        begin
            wr_ok(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_SET_BIT, 3'(b), 6'h05, 8'h00));
            ctr = ctr + `MBL_PC_STEP;
            rd_chk(`MBL_OFS_FDATA, (32'h2 << b) - 32'h1);
        end
        wr_ok(`MBL_OFS_FADDR, 32'h0000003f);
        wr_ok(`MBL_OFS_FDATA, 32'h0000005a);
        wr_ok(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_SET_BIT, 3'h2, 6'h3f, 8'h00));
        ctr = ctr + `MBL_PC_STEP;
        rd_chk(`MBL_OFS_FDATA, 32'h0000005e);
        rd_chk(`MBL_OFS_STATUS, st(1'b1, 3'h0));
        // Both skip polarities, taken and not taken
        for (int i = 0; i < 5; i++)
        begin
            wr_ok(`MBL_OFS_EXEC, mk(sk_op[i], sk_bit[i], 6'h3f, 8'h00));
            ctr = ctr + sk_step[i];
            rd_chk(`MBL_OFS_PC, 32'(ctr));
        end
        rd_chk(`MBL_OFS_STATUS, st(1'b1, 3'h0));
        // Direct call from 0x0a0 with page buffer 2
        wr_ok(`MBL_OFS_PC, 32'h000000a0);
        wr_ok(`MBL_OFS_PAGE, 32'h00000002);
        wr_ok(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_CALL_DIR, 3'h0, 6'h00, 8'h34));
        rd_chk(`MBL_OFS_PC, 32'h00000234);
        wr_ok(`MBL_OFS_SSEL, 32'h00000000);
        rd_chk(`MBL_OFS_SDATA, 32'h000000a1);
        rd_chk(`MBL_OFS_STATUS, st(1'b1, 3'h1));
        // Indirect call: only the pointer's low two bits reach the page
        wr_ok(`MBL_OFS_TABLE_HIGH_POINTER, 32'h000000fe);
        rd_chk(`MBL_OFS_TABLE_HIGH_POINTER, 32'h000000fe);
        wr_ok(`MBL_OFS_WREG, 32'h00000077);
        wr_ok(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_CALL_IND, 3'h0, 6'h00, 8'h00));
        rd_chk(`MBL_OFS_PC, 32'h00000277);
        wr_ok(`MBL_OFS_SSEL, 32'h00000001);
        rd_chk(`MBL_OFS_SDATA, 32'h00000235);
        // Six more calls wrap the eight-deep pointer back to zero
        ctr = 10'h277;
        for (int i = 0; i < 6; i++)
        begin
            ret = ctr + `MBL_PC_STEP;
            wr_ok(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_CALL_DIR, 3'h0, 6'h00, 8'(i)));
            ctr = {2'b10, 8'(i)};
        end
        rd_chk(`MBL_OFS_STATUS, st(1'b1, 3'h0));
        wr_ok(`MBL_OFS_SSEL, 32'h00000007);
        rd_chk(`MBL_OFS_SDATA, 32'(ret));
        rd_chk(`MBL_OFS_PC, 32'(ctr));
        // No-operation and unused codes only advance by one
        for (int op = 0; op < 16; op++)
        begin
            if (op == 0 || op > 6)
            begin
                wr_ok(`MBL_OFS_EXEC, mk(4'(op), 3'h0, 6'h00, 8'h00));
                ctr = ctr + `MBL_PC_STEP;
            end
        end
        rd_chk(`MBL_OFS_PC, 32'(ctr));
        rd_chk(`MBL_OFS_EXEC, mk(4'hf, 3'h0, 6'h00, 8'h00));
        // Partial strobes leave the instruction unissued
        axi_wr(`MBL_OFS_EXEC, mk(mbl_pkg::MBL_OP_AND_IMM, 3'h0, 6'h00, 8'h00), 4'h1, r);
        `CHK(r, `MBL_RESP_OKAY)
        rd_chk(`MBL_OFS_WREG, 32'h00000077);
        rd_chk(`MBL_OFS_PC, 32'(ctr));
        report_and_stop();
    end
endmodule // tb_top
